/* File: verilog/wdr_watchdog.sv */
// Notes on behaviour
// - Enabled watchdog whose counter overflows requests a whole-chip reset.
// - Single read/write control register at special register address e1.
// - Bit 7 set enables the watchdog; cleared disables it.
// - Writing 1 to bit 6 clears overflow counter and prescaler.
// - Bits 2 to 0 select the overflow interval.
// - Counting runs from crystal clock edges, not the core clock.
// - Period code 000 gives eight base units.
// - Period codes 001 to 111 give that many base units.
module wdr_watchdog #(
    parameter int PRESCALE_DIV = wdr_pkg::PRESCALE_DIV,
    parameter int UNIT_TICKS   = wdr_pkg::UNIT_TICKS
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Special register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic      [7:0] sfr_rdata,
    // Crystal pin
    input  wire logic       crystal_clock_in,
    // Reset request to the chip reset logic
    output logic            chip_reset_req
);

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    logic                    watchdog_enable_bit;
    logic [2:0]              period_sel;
    logic [3:0]              unit_count;
    wdr_pkg::wdr_state_type  state;
    wdr_pkg::wdr_state_type  next_state;
    logic                    unit_tick;

    wire       ctrl_hit   = (sfr_addr == wdr_pkg::CTRL_ADDR);
    wire       ctrl_write = sfr_wr && ctrl_hit;
    wire       ctrl_read  = sfr_rd && ctrl_hit;
    wire       watchdog_restart_bit = ctrl_write && sfr_wdata[wdr_pkg::RESTART_POS];
    wire       period_sel_bit2 = period_sel[2];
    wire       period_sel_bit1 = period_sel[1];
    wire       period_sel_bit0 = period_sel[0];

    // Restart bit is a strobe, never stored, so it reads back as zero
    wire [7:0] watchdog_control_reg = {watchdog_enable_bit, 1'b0, 3'h0,
                                       period_sel_bit2, period_sel_bit1, period_sel_bit0};

    // ----------------------------------------------------------------
    // Interval selection
    // ----------------------------------------------------------------
    // Code zero is the longest interval so a cleared field is never shortest
    wire [3:0] units_needed = (period_sel == 3'h0) ? wdr_pkg::ZERO_SEL_UNITS
                                                   : {1'b0, period_sel};
    wire       running      = (state == wdr_pkg::ST_RUN);
    wire       last_unit    = (unit_count == units_needed - 4'h1);
    wire       overflow     = running && unit_tick && last_unit;

    // ----------------------------------------------------------------
    // Control register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            watchdog_enable_bit <= wdr_pkg::ENABLE_RESET;
            period_sel          <= wdr_pkg::PERIOD_RESET;
        end else if (ctrl_write) begin
            watchdog_enable_bit <= sfr_wdata[wdr_pkg::ENABLE_POS];
            period_sel          <= sfr_wdata[wdr_pkg::PERIOD_MSB:wdr_pkg::PERIOD_LSB];
        end
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= wdr_pkg::SFR_RDATA_IDLE;
        end else if (ctrl_read) begin
            sfr_rdata <= watchdog_control_reg;
        end
    end

    // ----------------------------------------------------------------
    // Run state follows the enable bit
    // ----------------------------------------------------------------
    assign next_state = watchdog_enable_bit ? wdr_pkg::ST_RUN : wdr_pkg::ST_IDLE;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= wdr_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Prescaler and base-unit chain
    // ----------------------------------------------------------------
    wdr_prescaler #(
        .PRESCALE_DIV (PRESCALE_DIV),
        .UNIT_TICKS   (UNIT_TICKS)
    ) u_prescaler (
        .clk              (clk),
        .rst              (rst),
        .crystal_clock_in (crystal_clock_in),
        .run              (running),
        .clear            (watchdog_restart_bit),
        .unit_tick        (unit_tick)
    );

    // ----------------------------------------------------------------
    // Programmable overflow counter
    // ----------------------------------------------------------------
    // Disabled watchdog holds zero, so enabling starts a full interval
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unit_count <= wdr_pkg::UNIT_COUNT_RST;
        end else if (watchdog_restart_bit || !running) begin
            unit_count <= wdr_pkg::UNIT_COUNT_RST;
        end else if (unit_tick) begin
            unit_count <= last_unit ? wdr_pkg::UNIT_COUNT_RST : unit_count + 4'h1;
        end
    end

    // One-cycle reset request; restart in the overflow cycle still saves it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chip_reset_req <= 1'b0;
        end else begin
            chip_reset_req <= overflow && !watchdog_restart_bit;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_overflow_cause;
        running && unit_tick && last_unit && !watchdog_restart_bit;
    endsequence

    chk_overflow_resets: assert property (@(posedge clk) disable iff (rst)
        s_overflow_cause |=> chip_reset_req)
        else $error("overflow did not request a chip reset");

    chk_reset_has_cause: assert property (@(posedge clk) disable iff (rst)
        chip_reset_req |-> $past(running) && $past(unit_tick))
        else $error("reset request without an enabled overflow");

    chk_disabled_quiet: assert property (@(posedge clk) disable iff (rst)
        !watchdog_enable_bit |=> !running ##1 !chip_reset_req)
        else $error("disabled watchdog still running");

    chk_restart_clears: assert property (@(posedge clk) disable iff (rst)
        watchdog_restart_bit |=> unit_count == 4'h0 && !chip_reset_req)
        else $error("restart did not clear the counter");

    chk_read_back: assert property (@(posedge clk) disable iff (rst)
        ctrl_read |=> sfr_rdata == {$past(watchdog_enable_bit), 4'h0, $past(period_sel)})
        else $error("control register read back wrong");

    chk_write_fields: assert property (@(posedge clk) disable iff (rst)
        ctrl_write |=> period_sel == $past(sfr_wdata[2:0])
                       && watchdog_enable_bit == $past(sfr_wdata[7]))
        else $error("control write not stored");

    chk_zero_code_eight: assert property (@(posedge clk) disable iff (rst)
        (period_sel == 3'h0) |-> units_needed == 4'h8)
        else $error("code zero not eight units");

    chk_count_bound: assert property (@(posedge clk) disable iff (rst)
        unit_count < units_needed || ctrl_write || $past(ctrl_write))
        else $error("unit counter passed the selected interval");

    // ----------------------------------------------------------------
    // Sequencing checks
    // ----------------------------------------------------------------
    // Enable write left alone for one cycle, so the run state must follow
    sequence s_enable_write;
        ctrl_write && sfr_wdata[wdr_pkg::ENABLE_POS] ##1 !ctrl_write;
    endsequence

    // Restart strobe taken on this edge
    sequence s_restart_strobe;
        watchdog_restart_bit;
    endsequence

    // One unit boundary while the interval is still short of its end
    sequence s_mid_interval_tick;
        running && unit_tick && !last_unit && !watchdog_restart_bit;
    endsequence

    chk_enable_runs: assert property (@(posedge clk) disable iff (rst)
        s_enable_write |=> running)
        else $error("enabled watchdog did not start");

    // Cleared prescaler cannot finish a unit on the very next edge
    chk_restart_no_tick: assert property (@(posedge clk) disable iff (rst)
        s_restart_strobe |=> !unit_tick)
        else $error("unit tick right after restart");

    // Idle chain must start from zero when the enable returns
    chk_idle_zero: assert property (@(posedge clk) disable iff (rst)
        !running |=> unit_count == wdr_pkg::UNIT_COUNT_RST)
        else $error("disabled watchdog kept its count");

    chk_count_steps: assert property (@(posedge clk) disable iff (rst)
        s_mid_interval_tick |=> unit_count == $past(unit_count) + 4'h1)
        else $error("unit counter skipped a step");

    // Pulse, not a level: the chip reset logic sees one event per overflow
    chk_reset_pulse: assert property (@(posedge clk) disable iff (rst)
        chip_reset_req |=> !chip_reset_req)
        else $error("reset request held longer than one cycle");

    chk_other_addr: assert property (@(posedge clk) disable iff (rst)
        sfr_wr && !ctrl_hit |=> $stable(watchdog_enable_bit) && $stable(period_sel))
        else $error("write to another address changed the control");

    // Read data is only refreshed by a read of the control address
    chk_rdata_holds: assert property (@(posedge clk) disable iff (rst)
        !ctrl_read |=> $stable(sfr_rdata))
        else $error("read data changed without a read");

    chk_code_seven: assert property (@(posedge clk) disable iff (rst)
        (period_sel == 3'h7) |-> units_needed == 4'h7)
        else $error("code seven not seven units");

endmodule : wdr_watchdog

/* File: verilog/wdr_pkg.sv */
package wdr_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR      = 8'he1;  // Control register in special register space
    localparam int         ENABLE_POS     = 7;
    localparam int         RESTART_POS    = 6;
    localparam int         PERIOD_MSB     = 2;
    localparam int         PERIOD_LSB     = 0;
    localparam logic       ENABLE_RESET   = 1'b0;
    localparam logic [2:0] PERIOD_RESET   = 3'h0;
    localparam logic [7:0] SFR_RDATA_IDLE = 8'h00;

    // ----------------------------------------------------------------
    // Counting chain
    // ----------------------------------------------------------------
    localparam int         CRYSTAL_HZ     = 24_000_000; // Nominal crystal, for reference
    localparam int         PRESCALE_DIV   = 10000;      // Crystal edges per prescaler output
    localparam int         UNIT_TICKS     = 256;        // Prescaler outputs per base unit
    localparam logic [3:0] ZERO_SEL_UNITS = 4'h8;       // Period code zero means eight units
    localparam logic [3:0] UNIT_COUNT_RST = 4'h0;

    // ----------------------------------------------------------------
    // Run state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } wdr_state_type;

endpackage : wdr_pkg

/* File: verilog/wdr_prescaler.sv */
module wdr_prescaler #(
    parameter int PRESCALE_DIV = wdr_pkg::PRESCALE_DIV,
    parameter int UNIT_TICKS   = wdr_pkg::UNIT_TICKS
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Crystal pin
    input  wire logic crystal_clock_in,
    // Control
    input  wire logic run,
    input  wire logic clear,
    // One pulse per base unit
    output logic      unit_tick
);

    localparam int PW = $clog2(PRESCALE_DIV);
    localparam int UW = $clog2(UNIT_TICKS);

    logic          xtal_meta;
    logic          xtal_sync;
    logic          xtal_prev;
    logic [PW-1:0] presc_count;
    logic [UW-1:0] unit_sub;

    wire           xtal_edge = xtal_sync & ~xtal_prev;
    wire           presc_wrap = xtal_edge && (presc_count == PW'(PRESCALE_DIV - 1));
    wire           unit_wrap  = presc_wrap && (unit_sub == UW'(UNIT_TICKS - 1));
    wire           hold_zero  = clear || !run;

    // ----------------------------------------------------------------
    // Crystal synchroniser; only the second stage feeds the edge detect
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xtal_meta <= 1'b0;
            xtal_sync <= 1'b0;
            xtal_prev <= 1'b0;
        end else begin
            xtal_meta <= crystal_clock_in;
            xtal_sync <= xtal_meta;
            xtal_prev <= xtal_sync;
        end
    end

    // Divide crystal edges, then count prescaler outputs into a unit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            presc_count <= '0;
            unit_sub    <= '0;
        end else if (hold_zero) begin
            presc_count <= '0;
            unit_sub    <= '0;
        end else if (xtal_edge) begin
            presc_count <= presc_wrap ? '0 : presc_count + PW'(1);
            if (presc_wrap) begin
                unit_sub <= unit_wrap ? '0 : unit_sub + UW'(1);
            end
        end
    end

    // Restart wins over a unit boundary landing in the same cycle
    assign unit_tick = unit_wrap && !hold_zero;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_tick_on_edge: assert property (@(posedge clk) disable iff (rst)
        unit_tick |-> xtal_edge && presc_count == PW'(PRESCALE_DIV - 1))
        else $error("unit tick without crystal edge at prescaler end");

    chk_clear_chain: assert property (@(posedge clk) disable iff (rst)
        clear |=> presc_count == '0 && unit_sub == '0)
        else $error("restart did not clear the prescaler");

endmodule : wdr_prescaler

/* File: tb/test_watchdog_reset_timer.sv */
module test_watchdog_reset_timer;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // Setup
    // ----------------------------------------------------------------
    localparam int PDIV     = 2;
    localparam int UTK      = 2;
    localparam int XHALF    = 40;                     // Crystal at 12.5 MHz, well below a third of clk
    localparam int UNIT_CYC = PDIV * UTK * XHALF / 5; // Clock cycles per base unit

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic       sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic       sfr_rd = 1'b0;
    logic [7:0] sfr_rdata;
    logic       crystal_clock_in = 1'b0;
    logic       chip_reset_req;
    logic [7:0] exp_q[$];
    logic [7:0] lfsr = 8'h0d;
    logic       rd_seen = 1'b0;
    int         num_errors = 0;
    int         check_count = 0;
    int         cyc = 0;
    int         pulse_cnt = 0;
    int         pulse_cyc = 0;

    // Clocks: the crystal runs free at exactly eight clk periods, toggling on falling clk edges
    always #5 clk = ~clk;
    always #XHALF crystal_clock_in = ~crystal_clock_in;

    wdr_watchdog #(.PRESCALE_DIV(PDIV), .UNIT_TICKS(UTK)) dut_u (
        .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .crystal_clock_in(crystal_clock_in),
        .chip_reset_req(chip_reset_req));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        check_count++;
        if (seen !== expv) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, expv, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        idle(1);
        sfr_wr    = 1'b0;
        idle(1);
    endtask : wr

    // Expected byte is queued only for the mapped address
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        if (a == wdr_pkg::CTRL_ADDR) exp_q.push_back(e);
        idle(1);
        sfr_rd   = 1'b0;
        idle(1);
    endtask : rd

    // Enable with restart, then time the overflow pulse
    task automatic interval(input logic [2:0] code);
        int n;
        int t0;
        int p0;
        n  = (code == 3'h0) ? 8 : int'(code);
        p0 = pulse_cnt;
        wr(wdr_pkg::CTRL_ADDR, {2'b11, 3'b000, code});
        t0 = cyc;
        for (int i = 0; i < n * UNIT_CYC + 40 && pulse_cnt == p0; i++) idle(1);
        idle(1);
        check("pulse_count", pulse_cnt - p0, 1);
        check("interval_ok", (pulse_cyc - t0 > n * UNIT_CYC - 10) && (pulse_cyc - t0 < n * UNIT_CYC + 10), 1);
    endtask : interval

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next

    // ----------------------------------------------------------------
    // Output monitor
    // ----------------------------------------------------------------
    // Read data lands one edge after the read is taken
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rd_seen) check("sfr_rdata", sfr_rdata, exp_q.pop_front());
        rd_seen <= sfr_rd && (sfr_addr === wdr_pkg::CTRL_ADDR);
        if (chip_reset_req === 1'b1) begin
            pulse_cnt <= pulse_cnt + 1;
            pulse_cyc <= cyc;
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        int p0;
        idle(2);
        rst = 1'b0;
        rd(wdr_pkg::CTRL_ADDR, 8'h00);
        wr(wdr_pkg::CTRL_ADDR, 8'h05);
        rd(wdr_pkg::CTRL_ADDR, 8'h05);
        rd(8'he0, 8'h00);
        wr(8'he2, 8'h87);
        idle(1);
        check("rdata_hold", sfr_rdata, 8'h05);
        rd(wdr_pkg::CTRL_ADDR, 8'h05);
        wr(wdr_pkg::CTRL_ADDR, 8'hff);
        rd(wdr_pkg::CTRL_ADDR, 8'h87);
        // Random bytes: only enable and period bits read back
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(wdr_pkg::CTRL_ADDR, lfsr);
            rd(wdr_pkg::CTRL_ADDR, {lfsr[7], 4'h0, lfsr[2:0]});
        end
        // Every period code, back to back
        for (int c = 0; c < 8; c++) interval(3'(c));
        // Disabled watchdog never fires
        wr(wdr_pkg::CTRL_ADDR, 8'h01);
        p0 = pulse_cnt;
        idle(5 * UNIT_CYC);
        check("disabled_pulses", pulse_cnt - p0, 0);
        rd(wdr_pkg::CTRL_ADDR, 8'h01);
        // Regular restarts hold off the overflow
        wr(wdr_pkg::CTRL_ADDR, 8'h82);
        p0 = pulse_cnt;
        for (int i = 0; i < 4; i++) begin
            idle(UNIT_CYC * 3 / 2);
            wr(wdr_pkg::CTRL_ADDR, 8'hc2);
        end
        check("restart_pulses", pulse_cnt - p0, 0);
        interval(3'h2);
        wr(wdr_pkg::CTRL_ADDR, 8'h00);
        idle(3);
        complete_run();
    end

    // Watchdog on the bench itself
    initial begin
        #200000;
        num_errors++;
        $display("BAD run_time expected finish seen timeout");
        complete_run();
    end

endmodule : test_watchdog_reset_timer
